/* common/fdr_pkg.sv */
// Package with register map, field layout, reset values and carrier types of the flash driver register bank.
// Summary of operation
// - Auxiliary bit 7 enables dynamic overvoltage protection; resets off.
// - Auxiliary bit 6 forces the slower 1.5 MHz switching rate; resets off.
// - Auxiliary bit 5 picks strobe polarity, 0 low, 1 high; resets high.
// - Auxiliary bits 4:3 pick indicator current 2.75 to 11 mA; reset 00.
// - Auxiliary bits 2:1 pick input current limit; 11 reserved; reset 10.
// - Auxiliary bit 0 enables the input current limit; resets off.
// - Readback bit 6 shows supply below threshold, only when threshold enabled.
// - Readback bits 5:2 present the four bit conversion result.
// - Readback bits 1:0 select converter channel; resets disabled.
// - Battery bit 7 clear means shutdown at peak limit; set means soft limiting.
// - Battery bits 6:3 read only current code, default 1010, 1111 reserved.
// - Battery bits 2:0 set threshold, 000 disabled, 3.3 to 3.6 V.
package fdr_pkg;

   // Register offsets.
   localparam logic [7:0] ADDR_AUX     = 8'h07;
   localparam logic [7:0] ADDR_READBK  = 8'h08;
   localparam logic [7:0] ADDR_BATT    = 8'h09;

   // Reset values of the three registers.
   localparam logic [7:0] RST_AUX      = 8'h24;
   localparam logic [7:0] RST_READBK   = 8'h00;
   localparam logic [7:0] RST_BATT     = 8'hd0;

   // Field positions in the auxiliary mode register.
   localparam int AUX_OVP_BIT    = 7;
   localparam int AUX_SLOW_BIT   = 6;
   localparam int AUX_POL_BIT    = 5;
   localparam int AUX_ILED_LSB   = 3;
   localparam int AUX_LIM_LSB    = 1;
   localparam int AUX_LIM_EN_BIT = 0;

   // Field positions in the readback control register.
   localparam int RB_TEST_BIT    = 7;
   localparam int RB_FLAG_BIT    = 6;
   localparam int RB_RESULT_LSB  = 2;
   localparam int RB_SEL_LSB     = 0;

   // Field positions in the low battery register.
   localparam int LB_SOFT_BIT    = 7;
   localparam int LB_CUR_LSB     = 3;
   localparam int LB_THR_LSB     = 0;

   // Fixed codes.
   localparam logic [1:0] LIM_RESERVED    = 2'h3;
   localparam logic [3:0] LB_CURRENT_CODE = 4'ha;
   localparam logic [2:0] THR_DISABLED    = 3'h0;

   // Register access request as delivered by the serial interface engine.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fdr_req_t;

   // Converter result delivered by the measurement logic.
   typedef struct packed {
      logic       valid;
      logic [3:0] data;
   } fdr_conv_t;

   // Decoded configuration toward the analog sections.
   typedef struct packed {
      logic       dynamic_overvoltage_enable;
      logic       force_slow_switching;
      logic       strobe_polarity;
      logic [1:0] indicator_current_select;
      logic [1:0] input_current_limit_select;
      logic       input_current_limit_enable;
      logic       test_mode;
      logic [1:0] adc_channel;
      logic       soft_peak_limit_enable;
      logic [2:0] low_battery_threshold;
      logic [3:0] low_battery_current;
      logic       low_battery_flag;
      logic       low_battery_limit_active;
   } fdr_cfg_t;

   // Channel selection codes.
   typedef enum logic [1:0] {
      FDR_ADC_OFF,
      FDR_ADC_FORWARD,
      FDR_ADC_DIE_TEMP,
      FDR_ADC_EXTERNAL
   } fdr_adc_sel_t;

endpackage

/* rtl/fdr_sync.sv */
// Three stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module fdr_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } fdr_sync_state_t;

   fdr_sync_state_t st;
   fdr_sync_state_t next_st;

   // Shift the pins in; the output follows only where stages two and three agree.
   always_comb
   begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   // Register the state.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dout = st.q;

endmodule

/* rtl/fdr_regs.sv */
// Register bank for auxiliary mode, converter readback and low battery control.
`timescale 1ns/1ps
module fdr_regs (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire fdr_pkg::fdr_req_t  reg_req,
   output logic      [7:0]       reg_rdata,
   input  wire logic             battery_below_pin,
   input  wire logic             strobe_pin,
   input  wire fdr_pkg::fdr_conv_t conv,
   output logic                  strobe_active,
   output fdr_pkg::fdr_cfg_t     cfg
);

   // ----------------------------------------------------------------
   // State of the bank: stored fields plus the read data register.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] aux;
      logic       test_mode;
      logic [3:0] result;
      logic [1:0] adc_sel;
      logic       soft_limit;
      logic [2:0] threshold;
      logic       flag;
      logic       strobe;
      logic [7:0] rdata;
   } fdr_regs_state_t;

   fdr_regs_state_t st;
   fdr_regs_state_t next_st;
   logic [1:0]      pins_q;
   logic            below_q;
   logic            strobe_q;

   // Decode one register offset for a read or a write.
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
      hits = (addr == target);
   endfunction

   // ----------------------------------------------------------------
   // Bring the comparator and strobe pins into the clock domain.
   // ----------------------------------------------------------------
   fdr_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .din     ({battery_below_pin, strobe_pin}),
      .dout    (pins_q)
   );

   assign below_q  = pins_q[1];
   assign strobe_q = pins_q[0];

   // ----------------------------------------------------------------
   // Next state: host writes, converter updates, flag and readback.
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      if (reg_req.wr && hits(reg_req.addr, fdr_pkg::ADDR_AUX))
      begin
         next_st.aux = reg_req.wdata;
         if (reg_req.wdata[fdr_pkg::AUX_LIM_LSB +: 2] == fdr_pkg::LIM_RESERVED)
         begin
            next_st.aux[fdr_pkg::AUX_LIM_LSB +: 2] = st.aux[fdr_pkg::AUX_LIM_LSB +: 2];
         end
      end
      if (reg_req.wr && hits(reg_req.addr, fdr_pkg::ADDR_READBK))
      begin
         next_st.test_mode = reg_req.wdata[fdr_pkg::RB_TEST_BIT];
         next_st.result    = reg_req.wdata[fdr_pkg::RB_RESULT_LSB +: 4];
         next_st.adc_sel   = reg_req.wdata[fdr_pkg::RB_SEL_LSB +: 2];
      end
      if (conv.valid)
      begin
         next_st.result = conv.data;
      end
      if (reg_req.wr && hits(reg_req.addr, fdr_pkg::ADDR_BATT))
      begin
         next_st.soft_limit = reg_req.wdata[fdr_pkg::LB_SOFT_BIT];
         next_st.threshold  = reg_req.wdata[fdr_pkg::LB_THR_LSB +: 3];
      end
      next_st.flag = below_q && (st.threshold != fdr_pkg::THR_DISABLED);
      next_st.strobe = (strobe_q == st.aux[fdr_pkg::AUX_POL_BIT]);
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            fdr_pkg::ADDR_AUX:
            begin
               next_st.rdata = st.aux;
            end
            fdr_pkg::ADDR_READBK:
            begin
               next_st.rdata = {st.test_mode, st.flag, st.result, st.adc_sel};
            end
            fdr_pkg::ADDR_BATT:
            begin
               next_st.rdata = {st.soft_limit, fdr_pkg::LB_CURRENT_CODE, st.threshold};
            end
            default:
            begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register the state; reset loads the default register values.
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st            <= '0;
         st.aux        <= fdr_pkg::RST_AUX;
         st.test_mode  <= fdr_pkg::RST_READBK[fdr_pkg::RB_TEST_BIT];
         st.soft_limit <= fdr_pkg::RST_BATT[fdr_pkg::LB_SOFT_BIT];
         st.threshold  <= fdr_pkg::RST_BATT[fdr_pkg::LB_THR_LSB +: 3];
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Drive the decoded fields out of the register bank.
   // ----------------------------------------------------------------
   always_comb
   begin
      cfg.dynamic_overvoltage_enable = st.aux[fdr_pkg::AUX_OVP_BIT];
      cfg.force_slow_switching       = st.aux[fdr_pkg::AUX_SLOW_BIT];
      cfg.strobe_polarity            = st.aux[fdr_pkg::AUX_POL_BIT];
      cfg.indicator_current_select   = st.aux[fdr_pkg::AUX_ILED_LSB +: 2];
      cfg.input_current_limit_select = st.aux[fdr_pkg::AUX_LIM_LSB +: 2];
      cfg.input_current_limit_enable = st.aux[fdr_pkg::AUX_LIM_EN_BIT];
      cfg.test_mode                  = st.test_mode;
      cfg.adc_channel                = st.adc_sel;
      cfg.soft_peak_limit_enable     = st.soft_limit;
      cfg.low_battery_threshold      = st.threshold;
      cfg.low_battery_current        = fdr_pkg::LB_CURRENT_CODE;
      cfg.low_battery_flag           = st.flag;
      cfg.low_battery_limit_active   = st.flag && (st.threshold != fdr_pkg::THR_DISABLED);
   end

   assign reg_rdata     = st.rdata;
   assign strobe_active = st.strobe;

   // ----------------------------------------------------------------
   // Checks on the register bank.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_aux_write;
      reg_req.wr && reg_req.addr == fdr_pkg::ADDR_AUX;
   endsequence

   sequence s_batt_read;
      reg_req.rd && reg_req.addr == fdr_pkg::ADDR_BATT;
   endsequence

   sequence s_batt_write;
      reg_req.wr && reg_req.addr == fdr_pkg::ADDR_BATT;
   endsequence

   a_aux_reset_value: assert property ($rose(rst_n) |-> st.aux == 8'h24 && st.soft_limit && st.threshold == 3'h0)
      else $error("Register defaults wrong after reset.");

   a_dynamic_overvoltage_protection_write: assert property (s_aux_write |=> cfg.dynamic_overvoltage_enable == $past(reg_req.wdata[7]))
      else $error("Overvoltage enable does not follow the write.");

   a_slow_switch_write: assert property (s_aux_write |=> cfg.force_slow_switching == $past(reg_req.wdata[6]))
      else $error("Slow switching bit does not follow the write.");

   a_iled_write: assert property (s_aux_write |=> cfg.indicator_current_select == $past(reg_req.wdata[4:3]))
      else $error("Indicator current does not follow the write.");

   a_limit_reserved_kept: assert property (s_aux_write ##0 reg_req.wdata[2:1] == 2'h3
      |=> $stable(cfg.input_current_limit_select))
      else $error("Reserved limit code was accepted.");

   a_limit_en_write: assert property (s_aux_write |=> cfg.input_current_limit_enable == $past(reg_req.wdata[0]))
      else $error("Limit enable does not follow the write.");

   a_flag_disabled: assert property (st.threshold == 3'h0 |=> !cfg.low_battery_flag)
      else $error("Low battery flag set while mode disabled.");

   a_flag_from_pin: assert property (st.threshold != 3'h0 && below_q |=> cfg.low_battery_flag)
      else $error("Low battery flag missed a low supply.");

   a_result_update: assert property (conv.valid |=> st.result == $past(conv.data))
      else $error("Conversion result not captured.");

   a_sel_write: assert property (reg_req.wr && reg_req.addr == fdr_pkg::ADDR_READBK
      |=> cfg.adc_channel == $past(reg_req.wdata[1:0]))
      else $error("Channel select does not follow the write.");

   a_batt_readback: assert property (s_batt_read |=> reg_rdata == {$past(cfg.soft_peak_limit_enable),
      fdr_pkg::LB_CURRENT_CODE, $past(cfg.low_battery_threshold)})
      else $error("Low battery register readback wrong.");

   a_limit_tracks_flag: assert property (cfg.low_battery_flag && cfg.low_battery_threshold != 3'h0
      |-> cfg.low_battery_limit_active)
      else $error("LED current not limited while flagged.");

   a_strobe_follows: assert property (strobe_q == cfg.strobe_polarity |=> strobe_active)
      else $error("Strobe not active at the selected polarity.");

   a_soft_limit_write: assert property (s_batt_write |=> cfg.soft_peak_limit_enable == $past(reg_req.wdata[7]))
      else $error("Soft limit bit does not follow the write.");

   a_threshold_write: assert property (s_batt_write |=> cfg.low_battery_threshold == $past(reg_req.wdata[2:0]))
      else $error("Threshold field does not follow the write.");

endmodule

/* test/fdr_host.sv */
// Host model that issues byte register requests toward the register bank.
`timescale 1ns/1ps
module fdr_host (
   input  wire logic         clk_sys,
   output fdr_pkg::fdr_req_t reg_req,
   input  wire logic [7:0]   reg_rdata
);
   // Request lines start idle.
   initial
   begin
      reg_req = '0;
   end

   // Hides stale address and data once a request is released.
   task automatic release_bus();
      reg_req.wr = 1'b0;
      reg_req.rd = 1'b0;
      reg_req.addr = ~reg_req.addr;
      reg_req.wdata = ~reg_req.wdata;
   endtask

   // One write request, held through the edge that takes it.
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      #1;
      reg_req.addr = addr;
      reg_req.wdata = (addr == fdr_pkg::ADDR_READBK) ? (data & 8'h7f) : data;
      reg_req.wr = 1'b1;
      @(posedge clk_sys);
      #1;
      release_bus();
   endtask

   // One read request; data is taken after the edge that takes it.
   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      #1;
      reg_req.addr = addr;
      reg_req.rd = 1'b1;
      @(posedge clk_sys);
      #1;
      data = reg_rdata;
      release_bus();
   endtask
endmodule

/* test/test_fdr_regs.sv */
// Self-checking testbench for the flash driver register bank.
`timescale 1ns/1ps
module test_fdr_regs;
   logic               clk_sys;
   logic               rst_n;
   fdr_pkg::fdr_req_t  reg_req;
   logic [7:0]         reg_rdata;
   logic               battery_below_pin;
   logic               strobe_pin;
   fdr_pkg::fdr_conv_t conv;
   logic               strobe_active;
   fdr_pkg::fdr_cfg_t  cfg;
   logic [7:0]         rdv;
   logic [7:0]         b;
   int                 n_errors;
   int                 checked;

   fdr_regs fdr_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .battery_below_pin(battery_below_pin), .strobe_pin(strobe_pin), .conv(conv),
      .strobe_active(strobe_active), .cfg(cfg));

   fdr_host fdr_host_inst (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

   // Clock at 25 MHz.
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Compares one value and counts the result.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Waits a number of edges and steps just past the last one.
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Main sequence.
   initial
   begin
      n_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      battery_below_pin = 1'b0;
      strobe_pin = 1'b0;
      conv = '0;
      cycles(10);
      rst_n = 1'b1;
      check(reg_rdata, 8'h00);
      fdr_host_inst.read(8'h07, rdv);
      check(rdv, 8'h24);
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h00);
      fdr_host_inst.read(8'h09, rdv);
      check(rdv, 8'hd0);
      fdr_host_inst.write(8'h07, 8'hff);
      fdr_host_inst.read(8'h07, rdv);
      check(rdv, 8'hfd);
      check({7'h0, cfg.dynamic_overvoltage_enable}, 8'h01);
      check({7'h0, cfg.force_slow_switching}, 8'h01);
      check({7'h0, cfg.input_current_limit_enable}, 8'h01);
      check({7'h0, cfg.strobe_polarity}, 8'h01);
      // Indicator codes and limit codes, the reserved one last.
      for (int i = 0; i < 4; i++)
      begin
         b = {3'b001, i[1:0], i[1:0], 1'b0};
         fdr_host_inst.write(8'h07, b);
         fdr_host_inst.read(8'h07, rdv);
         check(rdv, (i == 3) ? 8'h3c : b);
         check({6'h0, cfg.indicator_current_select}, {6'h0, i[1:0]});
         check({6'h0, cfg.input_current_limit_select}, (i == 3) ? 8'h02 : {6'h0, i[1:0]});
      end
      strobe_pin = 1'b1;
      cycles(8);
      check({7'h0, strobe_active}, 8'h01);
      fdr_host_inst.write(8'h07, 8'h04);
      cycles(2);
      check({7'h0, cfg.strobe_polarity}, 8'h00);
      check({7'h0, strobe_active}, 8'h00);
      strobe_pin = 1'b0;
      cycles(8);
      check({7'h0, strobe_active}, 8'h01);
      // Every channel code; the flag bit is not writable.
      for (int i = 0; i < 4; i++)
      begin
         fdr_host_inst.write(8'h08, {2'b01, 4'h9, i[1:0]});
         fdr_host_inst.read(8'h08, rdv);
         check(rdv, {2'b00, 4'h9, i[1:0]});
         check({6'h0, cfg.adc_channel}, {6'h0, i[1:0]});
         check({7'h0, cfg.test_mode}, 8'h00);
      end
      conv.valid = 1'b1;
      conv.data = 4'h6;
      cycles(1);
      conv = '0;
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h1b);
      fdr_host_inst.write(8'h09, 8'h00);
      fdr_host_inst.read(8'h09, rdv);
      check(rdv, 8'h50);
      check({7'h0, cfg.soft_peak_limit_enable}, 8'h00);
      fdr_host_inst.write(8'h09, 8'hff);
      fdr_host_inst.read(8'h09, rdv);
      check(rdv, 8'hd7);
      check({5'h0, cfg.low_battery_threshold}, 8'h07);
      check({4'h0, cfg.low_battery_current}, 8'h0a);
      // Low supply with the threshold off, then on, then recovered.
      fdr_host_inst.write(8'h09, 8'h80);
      battery_below_pin = 1'b1;
      cycles(8);
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h1b);
      check({7'h0, cfg.low_battery_limit_active}, 8'h00);
      fdr_host_inst.write(8'h09, 8'h83);
      cycles(8);
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h5b);
      check({7'h0, cfg.low_battery_flag}, 8'h01);
      check({7'h0, cfg.low_battery_limit_active}, 8'h01);
      battery_below_pin = 1'b0;
      cycles(8);
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h1b);
      // Unmapped offset is ignored and reads zero.
      fdr_host_inst.write(8'h0a, 8'hff);
      fdr_host_inst.read(8'h0a, rdv);
      check(rdv, 8'h00);
      fdr_host_inst.read(8'h07, rdv);
      check(rdv, 8'h04);
      // A reset in mid-run brings every register back to its default.
      rst_n = 1'b0;
      cycles(4);
      rst_n = 1'b1;
      check(reg_rdata, 8'h00);
      fdr_host_inst.read(8'h07, rdv);
      check(rdv, 8'h24);
      fdr_host_inst.read(8'h08, rdv);
      check(rdv, 8'h00);
      fdr_host_inst.read(8'h09, rdv);
      check(rdv, 8'hd0);
      check({7'h0, strobe_active}, 8'h00);
      results();
   end

   // Watchdog well beyond the expected run length.
   initial
   begin
      #200000;
      n_errors++;
      results();
   end
endmodule
